// ---- shared/amrt_pkg.sv ----
// Contract
// - Four region control registers, each shaping only its own chip-enable region; here the last-read region's bits 15-14 also delay another region's access.
// - Synchronous or SDRAM kind: other fields ignored, no access generated here.
// - Asynchronous kind: register fields time address and control pins of accesses.
// - Writes: address, enable, byte enables lead write strobe by bits 31-28 cycles.
// - Reads: address, enables and output enable lead read strobe by bits 19-16.
// - Write strobe stays low for the bits 27-22 count, 0 to 63.
// - Write trail count is {bit 3, bits 21-20} after write strobe rises.
// - Read strobe stays low for the bits 13-8 count, 0 to 63.
// - Read trail bits 2-0 holds address, byte enables, output enable after strobe.
// - Idle turnaround bits 15-14 after read before write or other-region read.
// - Kind 0,1h,2h,Ch select 8,16,32,64-bit asynchronous memory.
// - Kind Ah,Bh,4h,Eh mean programmable synchronous memory of 8,16,32,64 bits.
// - All phase counts are cycles of the primary output clock.
// - Secondary instance rejects 32- and 64-bit kind codes.
package amrt_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int unsigned AMRT_REGIONS = 4;
	localparam logic [7:0] AMRT_OFF_REGION0 = 8'h00;
	localparam logic [7:0] AMRT_OFF_STATUS = 8'h10;
	localparam logic [31:0] AMRT_REGION_RESET = 32'hffff_ff03;
	localparam logic [1:0] AMRT_RESP_OKAY = 2'h0;
	localparam logic [1:0] AMRT_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned AMRT_WR_LEAD_LSB = 28;
	localparam int unsigned AMRT_WR_PULSE_LSB = 22;
	localparam int unsigned AMRT_WR_TRAIL_LSB = 20;
	localparam int unsigned AMRT_RD_LEAD_LSB = 16;
	localparam int unsigned AMRT_TURN_LSB = 14;
	localparam int unsigned AMRT_RD_PULSE_LSB = 8;
	localparam int unsigned AMRT_KIND_LSB = 4;
	localparam int unsigned AMRT_WR_TOP_BIT = 3;
	localparam int unsigned AMRT_RD_TRAIL_LSB = 0;

	// ------------------------------------------------------------
	// memory kind codes
	// ------------------------------------------------------------
	localparam logic [3:0] AMRT_ASYNC8 = 4'h0;
	localparam logic [3:0] AMRT_ASYNC16 = 4'h1;
	localparam logic [3:0] AMRT_ASYNC32 = 4'h2;
	localparam logic [3:0] AMRT_SDRAM32 = 4'h3;
	localparam logic [3:0] AMRT_SYNC32 = 4'h4;
	localparam logic [3:0] AMRT_SDRAM8 = 4'h8;
	localparam logic [3:0] AMRT_SDRAM16 = 4'h9;
	localparam logic [3:0] AMRT_SYNC8 = 4'ha;
	localparam logic [3:0] AMRT_SYNC16 = 4'hb;
	localparam logic [3:0] AMRT_ASYNC64 = 4'hc;
	localparam logic [3:0] AMRT_SDRAM64 = 4'hd;
	localparam logic [3:0] AMRT_SYNC64 = 4'he;

	// decoded timing of one region
	typedef struct packed {
		logic is_async;
		logic [1:0] width;
		logic [3:0] wr_lead;
		logic [5:0] wr_pulse;
		logic [2:0] wr_trail;
		logic [3:0] rd_lead;
		logic [5:0] rd_pulse;
		logic [2:0] rd_trail;
		logic [1:0] turn;
	} amrt_timing_t;

	typedef enum logic [2:0] {AMRT_IDLE, AMRT_TURN, AMRT_LEAD, AMRT_PULSE,
		AMRT_TRAIL} amrt_phase_t;

endpackage

// ---- shared/amrt_cfg_if.sv ----
// region word in, decoded timing out
interface amrt_cfg_if;
	import amrt_pkg::*;
	logic [31:0] word;
	logic secondary;
	amrt_timing_t timing;
	modport decoder (input word, input secondary, output timing);
	modport user (output word, output secondary, input timing);
endinterface

// ---- hdl/amrt_decode.sv ----
module amrt_decode
	import amrt_pkg::*;
(
	amrt_cfg_if.decoder port
);

	wire [3:0] kind = port.word[AMRT_KIND_LSB +: 4];
	// ------------------------------------------------------------
	// kind decode
	// ------------------------------------------------------------
	// only the four async codes reach the strobe engine
	wire async_code = kind == AMRT_ASYNC8 || kind == AMRT_ASYNC16
		|| kind == AMRT_ASYNC32 || kind == AMRT_ASYNC64;
	// wide codes of every kind, refused on the secondary instance
	wire wide_code = kind == AMRT_ASYNC32 || kind == AMRT_SDRAM32
		|| kind == AMRT_SYNC32 || kind == AMRT_ASYNC64
		|| kind == AMRT_SDRAM64 || kind == AMRT_SYNC64;
	wire unsupported = port.secondary && wide_code;
	logic [1:0] width;

	// bus width per kind; sdram and sync widths decoded but never captured for status
	always_comb
	begin
		case (kind)
			AMRT_ASYNC8, AMRT_SDRAM8, AMRT_SYNC8: width = 2'h0;
			AMRT_ASYNC16, AMRT_SDRAM16, AMRT_SYNC16: width = 2'h1;
			AMRT_ASYNC32, AMRT_SDRAM32, AMRT_SYNC32: width = 2'h2;
			AMRT_ASYNC64, AMRT_SDRAM64, AMRT_SYNC64: width = 2'h3;
			default: width = 2'h0; // reserved codes
		endcase
	end

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	// timing fields pass for every kind; only is_async is limited to async kinds
	assign port.timing.is_async = async_code && !unsupported;
	assign port.timing.width = width;
	assign port.timing.wr_lead = port.word[AMRT_WR_LEAD_LSB +: 4];
	assign port.timing.wr_pulse = port.word[AMRT_WR_PULSE_LSB +: 6];
	assign port.timing.wr_trail = {port.word[AMRT_WR_TOP_BIT],
		port.word[AMRT_WR_TRAIL_LSB +: 2]};
	assign port.timing.rd_lead = port.word[AMRT_RD_LEAD_LSB +: 4];
	assign port.timing.rd_pulse = port.word[AMRT_RD_PULSE_LSB +: 6];
	assign port.timing.rd_trail = port.word[AMRT_RD_TRAIL_LSB +: 3];
	assign port.timing.turn = port.word[AMRT_TURN_LSB +: 2];

endmodule // amrt_decode

// ---- hdl/amrt_top.sv ----
module amrt_top
	import amrt_pkg::*;
#(
	parameter bit SECONDARY = 1'b0
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic aclken,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// access request side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [1:0] req_region,
	input wire logic [19:0] req_addr,
	input wire logic [7:0] req_be,
	input wire logic [63:0] req_wdata,
	output logic done,
	output logic done_error,
	output logic [63:0] done_rdata,
	// memory pins
	output logic [3:0] chip_enable_n,
	output logic [19:0] external_address,
	output logic [7:0] byte_enables_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic output_enable_n,
	input wire logic [63:0] data_in,
	output logic [63:0] data_out,
	output logic data_oe
);

	// ------------------------------------------------------------
	// region registers and decoders
	// ------------------------------------------------------------
	logic [31:0] region_control [AMRT_REGIONS];
	amrt_timing_t timing_a [AMRT_REGIONS];
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire wr_commit = aclken && aw_held && w_held && !s_axi_bvalid;
	wire [31:0] wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
		{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire wr_on_region = aw_addr[7:4] == AMRT_OFF_REGION0[7:4]
		&& aw_addr[1:0] == 2'h0;
	wire [1:0] wr_index = aw_addr[3:2];

	// one register and one decoder per chip-enable region
	for (genvar i = 0; i < AMRT_REGIONS; i++)
	begin : gen_region
		amrt_cfg_if cfg ();
		wire hit = wr_commit && wr_on_region && wr_index == 2'(i);
		assign cfg.word = region_control[i];
		assign cfg.secondary = SECONDARY;
		assign timing_a[i] = cfg.timing;
		amrt_decode u_decode (.port(cfg.decoder));
		// byte lanes merged under wstrb
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				region_control[i] <= AMRT_REGION_RESET;
			else if (hit)
				region_control[i] <= (region_control[i] & ~wr_mask)
					| (w_data & wr_mask);
		end
	end

	// ------------------------------------------------------------
	// axi write channel
	// ------------------------------------------------------------
	// address and data taken in either order, answered once both held
	assign s_axi_awready = aclken && !aw_held && !s_axi_bvalid;
	assign s_axi_wready = aclken && !w_held && !s_axi_bvalid;
	wire wr_mapped = wr_on_region;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (aclken)
		begin
			if (aw_fire)
				aw_addr <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			aw_held <= wr_commit ? 1'b0 : (aw_held || aw_fire);
			w_held <= wr_commit ? 1'b0 : (w_held || w_fire);
		end
	end

	// write response; the status word is read-only and answers slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AMRT_RESP_OKAY;
		end
		else if (aclken)
		begin
			if (wr_commit)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? AMRT_RESP_OKAY : AMRT_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// access engine state
	// ------------------------------------------------------------
	amrt_phase_t state;
	amrt_phase_t next_state;
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	amrt_timing_t t_hold;
	logic is_write;
	logic [1:0] region;
	logic last_read;
	logic [1:0] last_region;

	// ------------------------------------------------------------
	// axi read channel
	// ------------------------------------------------------------
	wire rd_on_region = s_axi_araddr[7:4] == AMRT_OFF_REGION0[7:4]
		&& s_axi_araddr[1:0] == 2'h0;
	wire rd_on_status = s_axi_araddr == AMRT_OFF_STATUS;
	wire busy = state != AMRT_IDLE;
	// status shows the engine: busy, active region, direction, width
	wire [31:0] status_word = {24'h00_0000, t_hold.width, 1'b0,
		last_read, is_write, region, busy};
	wire [31:0] rd_word = rd_on_region ? region_control[s_axi_araddr[3:2]]
		: (rd_on_status ? status_word : 32'h0000_0000);

	assign s_axi_arready = aclken && !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AMRT_RESP_OKAY;
		end
		else if (aclken)
		begin
			if (ar_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_on_region || rd_on_status)
					? AMRT_RESP_OKAY : AMRT_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// phase selection
	// ------------------------------------------------------------
	// timing is latched at acceptance, so software writes during an
	// access only shape the next one
	assign req_ready = aclken && state == AMRT_IDLE;
	wire accept = req_valid && req_ready;
	wire amrt_timing_t sel_t = timing_a[req_region];
	wire amrt_timing_t cur_t = (state == AMRT_IDLE) ? sel_t : t_hold;
	wire cur_wr = (state == AMRT_IDLE) ? req_write : is_write;
	wire [5:0] lead_n = cur_wr ? {2'h0, cur_t.wr_lead}
		: {2'h0, cur_t.rd_lead};
	wire [5:0] pulse_n = cur_wr ? cur_t.wr_pulse
		: cur_t.rd_pulse;
	wire [5:0] trail_n = cur_wr ? {3'h0, cur_t.wr_trail}
		: {3'h0, cur_t.rd_trail};
	// zero-length phases are skipped, keeping lead, pulse, trail order
	wire amrt_phase_t to_trail = (trail_n != 6'h00) ? AMRT_TRAIL : AMRT_IDLE;
	wire amrt_phase_t to_pulse = (pulse_n != 6'h00) ? AMRT_PULSE : to_trail;
	wire [5:0] to_pulse_cnt = (pulse_n != 6'h00) ? pulse_n : trail_n;
	wire amrt_phase_t to_lead = (lead_n != 6'h00) ? AMRT_LEAD : to_pulse;
	wire [5:0] to_lead_cnt = (lead_n != 6'h00) ? lead_n : to_pulse_cnt;
	// idle gap after a read, before a write or another region's read
	wire need_turn = last_read && (req_write || req_region != last_region)
		&& t_hold.turn != 2'h0;
	wire phase_end = cnt == 6'h01;

	// phase sequencing, counting primary output clock cycles
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			AMRT_IDLE:
				if (accept && sel_t.is_async)
				begin
					next_state = need_turn ? AMRT_TURN : to_lead;
					next_cnt = need_turn ? {4'h0, t_hold.turn} : to_lead_cnt;
				end
			AMRT_TURN:
				if (phase_end)
				begin
					next_state = to_lead;
					next_cnt = to_lead_cnt;
				end
				else
					next_cnt = cnt - 6'h01;
			AMRT_LEAD:
				if (phase_end)
				begin
					next_state = to_pulse;
					next_cnt = to_pulse_cnt;
				end
				else
					next_cnt = cnt - 6'h01;
			AMRT_PULSE:
				if (phase_end)
				begin
					next_state = to_trail;
					next_cnt = trail_n;
				end
				else
					next_cnt = cnt - 6'h01;
			AMRT_TRAIL:
				if (phase_end)
					next_state = AMRT_IDLE;
				else
					next_cnt = cnt - 6'h01;
			default:
				next_state = AMRT_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= AMRT_IDLE;
			cnt <= 6'h00;
		end
		else if (aclken)
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// ------------------------------------------------------------
	// access capture
	// ------------------------------------------------------------
	// non-async regions are answered with an error and no pins move
	wire refuse = accept && !sel_t.is_async;
	wire start = accept && sel_t.is_async;
	wire finish = (busy || start) && next_state == AMRT_IDLE; // zero counts

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			t_hold <= '0;
			is_write <= 1'b0;
			region <= 2'h0;
			external_address <= 20'h0_0000;
			byte_enables_n <= 8'hff;
			data_out <= 64'h0;
		end
		else if (aclken && start)
		begin
			t_hold <= sel_t;
			is_write <= req_write;
			region <= req_region;
			external_address <= req_addr;
			byte_enables_n <= ~req_be;
			data_out <= req_wdata;
		end
	end

	// completion pulse, read data sampled through the read pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done <= 1'b0;
			done_error <= 1'b0;
			done_rdata <= 64'h0;
			last_read <= 1'b0;
			last_region <= 2'h0;
		end
		else if (aclken)
		begin
			done <= finish || refuse;
			done_error <= refuse;
			if (state == AMRT_PULSE && !is_write)
				done_rdata <= data_in;
			if (finish)
			begin
				last_read <= !cur_wr;
				last_region <= busy ? region : req_region;
			end
		end
	end

	// ------------------------------------------------------------
	// pin shaping
	// ------------------------------------------------------------
	wire in_access = state == AMRT_LEAD || state == AMRT_PULSE
		|| state == AMRT_TRAIL;
	// enable of the active region held across lead, pulse and trail
	assign chip_enable_n = in_access ? ~(4'h1 << region) : 4'hf;
	assign write_strobe_n = !(state == AMRT_PULSE && is_write);
	assign read_strobe_n = !(state == AMRT_PULSE && !is_write);
	// output enable leads and trails the read strobe
	assign output_enable_n = !(in_access && !is_write);
	assign data_oe = in_access && is_write;

endmodule // amrt_top

// ---- test/amrt_chk.sv ----
module amrt_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic done,
	input wire logic done_error,
	input wire logic [3:0] chip_enable_n,
	input wire logic [19:0] external_address,
	input wire logic [7:0] byte_enables_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic output_enable_n,
	input wire logic data_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic idle;
	// all chip enables high means no access on the pins
	assign idle = &chip_enable_n;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_one_region: assert property (
		$countones(~chip_enable_n) <= 1) else $error("two regions on");
	a_idle_quiet: assert property (
		idle |-> write_strobe_n && read_strobe_n && output_enable_n && !data_oe)
		else $error("strobe outside access");
	a_write_drive: assert property (
		!write_strobe_n |-> data_oe && output_enable_n)
		else $error("write strobe without data drive");
	a_read_oe: assert property (
		!read_strobe_n |-> !output_enable_n && !data_oe && write_strobe_n)
		else $error("read strobe without output enable");
	a_addr_hold: assert property (
		!idle && !$past(idle) |-> $stable(external_address) &&
		$stable(byte_enables_n)) else $error("address moved in access");
	a_end_done: assert property (
		$rose(idle) |-> done && !done_error) else $error("no done at end");
	a_err_quiet: assert property (
		done_error |-> done && idle && $past(idle))
		else $error("refused access touched pins");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule // amrt_chk

bind amrt_top amrt_chk amrt_chk_i (.aclk, .aresetn, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .done, .done_error, .chip_enable_n,
	.external_address, .byte_enables_n, .write_strobe_n, .read_strobe_n,
	.output_enable_n, .data_oe);

// ---- test/amrt_mem_model.sv ----
module amrt_mem_model (
	input wire logic aclk,
	input wire logic [3:0] chip_enable_n,
	input wire logic [19:0] external_address,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic [63:0] data_out,
	output logic [63:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] mem [16];
	logic [63:0] last;
	logic drive;
	// released bus shows the inverse of its last value, never a stale copy
	assign drive = !output_enable_n && !(&chip_enable_n);
	assign data_in = drive ? mem[external_address[3:0]] : ~last;
	initial
	begin
		last = 64'h0;
		for (int i = 0; i < 16; i++)
			mem[i] = {16{4'(i)}};
	end
	// array takes the bus on every strobe cycle, so the last one wins
	always @(posedge aclk)
	begin
		if (drive)
			last <= data_in;
		if (!write_strobe_n && !(&chip_enable_n))
			mem[external_address[3:0]] <= data_out;
	end
endmodule // amrt_mem_model

// ---- test/test_async_memory_region_timing.sv ----
module test_async_memory_region_timing
	import amrt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, aclken, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_valid, req_ready;
	logic req_write, done, done_error, write_strobe_n, read_strobe_n;
	logic output_enable_n, data_oe, err, ok;
	logic [7:0] s_axi_awaddr, s_axi_araddr, req_be, byte_enables_n;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv, w0, w1;
	logic [3:0] s_axi_wstrb, chip_enable_n;
	logic [1:0] s_axi_bresp, s_axi_rresp, req_region, resp;
	logic [19:0] req_addr, external_address;
	logic [63:0] req_wdata, done_rdata, data_in, data_out, rd;
	logic [3:0] kinds [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9,
		4'ha, 4'hb, 4'hc, 4'hd, 4'he};
	int bad_count, samples_checked, cyc;
	logic [31:0] idle_n, lead_n, pulse_n, trail_n, oe_n;

	amrt_top amrt_top_i (.aclk, .aresetn, .aclken, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid,
		.req_ready, .req_write, .req_region, .req_addr, .req_be, .req_wdata,
		.done, .done_error, .done_rdata, .chip_enable_n, .external_address,
		.byte_enables_n, .write_strobe_n, .read_strobe_n, .output_enable_n,
		.data_in, .data_out, .data_oe);
	amrt_mem_model amrt_mem_model_i (.aclk, .chip_enable_n, .external_address,
		.write_strobe_n, .output_enable_n, .data_out, .data_in);

	// ------------------------------------------------------------
	// clock, watchdog, checks
	// ------------------------------------------------------------
	always #50 aclk = ~aclk;
	// whole run is a few hundred cycles; this cuts a hang short
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			bad_count++;
			test_done;
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chkv(input string nm, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chkc(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	function automatic logic [31:0] mk(input logic [3:0] wl,
		input logic [5:0] wp, input logic [2:0] wt, input logic [3:0] rl,
		input logic [1:0] ta, input logic [5:0] rp, input logic [3:0] k,
		input logic [2:0] rt);
		return {wl, wp, wt[1:0], rl, ta, rp, k, wt[2], rt};
	endfunction

	// ------------------------------------------------------------
	// bus and access tasks
	// ------------------------------------------------------------
	// address and data offered together, each dropped once taken; ready
	// follows valid by a cycle, so a response held by the slave is seen
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb, rb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			rb = s_axi_bvalid;
			tb = rb && s_axi_bready;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			s_axi_bready <= rb && !tb;
		end while (!tb);
	endtask
	task axr(input logic [7:0] a);
		logic ta, tb, rb;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			rb = s_axi_rvalid;
			tb = rb && s_axi_rready;
			rv = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			s_axi_rready <= rb && !tb;
		end while (!tb);
	endtask
	// pins sampled mid-cycle; phases told apart by the strobe
	task acc(input logic w, input logic [1:0] g, input logic [19:0] a);
		logic p, c, s, t;
		logic [3:0] ce;
		logic [19:0] ea;
		logic [7:0] be;
		s = 0;
		{idle_n, lead_n, pulse_n, trail_n, oe_n} = '0;
		req_write <= w;
		req_region <= g;
		req_addr <= a;
		req_valid <= 1'b1;
		do
		begin
			@(negedge aclk);
			t = req_ready;
			@(posedge aclk);
		end while (!t);
		req_valid <= 1'b0;
		do
		begin
			@(negedge aclk);
			p = !write_strobe_n || !read_strobe_n;
			c = !(&chip_enable_n);
			s = s | p;
			pulse_n += p;
			trail_n += s && !p && c;
			lead_n += !s && c;
			idle_n += !c && !done;
			oe_n += !output_enable_n;
			{t, err, rd} = {done, done_error, done_rdata};
			if (c)
				{ce, ea, be} = {chip_enable_n, external_address, byte_enables_n};
			@(posedge aclk);
		end while (!t);
		// a granted access shows its own region and address on the pins
		if (!err)
		begin
			chkv("chip enable", 4'hf ^ (4'h1 << g), ce);
			chkv("address", a, ea);
			chkv("byte enables", 64'h0, be);
		end
	endtask
	task phases(input int l, input int p, input int h);
		chkc("lead cycles", l, lead_n);
		chkc("pulse cycles", p, pulse_n);
		chkc("trail cycles", h, trail_n);
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, req_valid, req_write} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_region} = '0;
		{req_addr, req_wdata, bad_count, samples_checked, cyc} = '0;
		aclken = 1'b1;
		s_axi_wstrb = 4'hf;
		req_be = 8'hff;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			axr(8'(4 * i));
			chkv("region reset", AMRT_REGION_RESET, rv);
		end
		axr(8'h20);
		chkv("unmapped resp", AMRT_RESP_SLVERR, resp);
		chkv("unmapped data", 0, rv);
		axw(8'h10, 32'h0);
		chkv("status write resp", AMRT_RESP_SLVERR, resp);
		$display("test reset done");
		// only legal kind codes are ever written
		w0 = mk(4'h2, 6'h3, 3'h5, 4'h1, 2'h2, 6'h4, AMRT_ASYNC32, 3'h2);
		w1 = mk(4'h1, 6'h1, 3'h0, 4'h3, 2'h1, 6'h2, AMRT_ASYNC64, 3'h0);
		axw(8'h00, w0);
		axw(8'h04, w1);
		axr(8'h00);
		chkv("region 0", w0, rv);
		axr(8'h04);
		chkv("region 1", w1, rv);
		axr(8'h0c);
		chkv("region 3", AMRT_REGION_RESET, rv);
		$display("test registers done");
		req_wdata <= 64'h0123_4567_89ab_cdef;
		acc(1'b1, 2'h0, 20'h3);
		phases(2, 3, 5);
		acc(1'b0, 2'h0, 20'h3);
		phases(1, 4, 2);
		chkc("read oe cycles", 7, oe_n);
		chkv("read data", 64'h0123_4567_89ab_cdef, rd);
		acc(1'b1, 2'h0, 20'h4);
		chkc("read to write gap", 2, idle_n);
		acc(1'b0, 2'h0, 20'h4);
		acc(1'b0, 2'h1, 20'h5);
		chkc("region change gap", 2, idle_n);
		phases(3, 2, 0);
		acc(1'b0, 2'h1, 20'h5);
		chkc("same region gap", 0, idle_n);
		acc(1'b1, 2'h1, 20'h6);
		chkc("write gap", 1, idle_n);
		phases(1, 1, 0);
		// idle engine, last access a write to region 1, 64-bit kind
		axr(AMRT_OFF_STATUS);
		chkv("status", 32'h0000_00ca, rv);
		$display("test timing done");
		foreach (kinds[i])
		begin
			axw(8'h08, mk(4'h1, 6'h1, 3'h0, 4'h1, 2'h0, 6'h1, kinds[i], 3'h0));
			acc(1'b1, 2'h2, 20'h7);
			ok = kinds[i] inside {AMRT_ASYNC8, AMRT_ASYNC16, AMRT_ASYNC32,
				AMRT_ASYNC64};
			chkv("kind refusal", !ok, err);
		end
		$display("test kinds done");
		test_done;
	end
endmodule // test_async_memory_region_timing
